// file: design/pfa_consts.svh
// Constants of the program-flow and indirect-addressing block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PFA_CONSTS_SVH
`define PFA_CONSTS_SVH

`define PFA_PC_W         13
`define PFA_DADDR_W      9
`define PFA_STACK_DEPTH  8
`define PFA_SP_W         3
`define PFA_TARGET_W     11
`define PFA_LATCH_W      5
`define PFA_ADR_WINDOW   7'h00
`define PFA_ADR_PC_LOW   7'h02
`define PFA_ADR_FILE_PTR 7'h04
`define PFA_ADR_LATCH    7'h0A
`define PFA_VECTOR       13'h0004
`define PFA_PC_RESET     13'h0000
`define PFA_FP_RESET     8'h00
`define PFA_LATCH_RESET  5'h00
`define PFA_PHASE_LAST   2'h3
`define PFA_PHASE_FIRST  2'h0
`define PFA_IRQ_LAT      2'h3

`endif

// file: design/pfa_pkg.sv
// Types shared by the program-flow block and its stack memory.
// Assumes the constants header is on the include path.
`include "pfa_consts.svh"

package pfa_pkg;

  typedef enum logic [2:0] {
    PFA_OP_NONE   = 3'b000,
    PFA_OP_STEP   = 3'b001,
    PFA_OP_GOTO   = 3'b010,
    PFA_OP_CALL   = 3'b011,
    PFA_OP_RETURN = 3'b100,
    PFA_OP_RETLIT = 3'b101,
    PFA_OP_RETIRQ = 3'b110
  } pfa_op_t;

  typedef struct packed {
    pfa_op_t                   op;
    logic [`PFA_TARGET_W-1:0]  target;
  } pfa_flow_t;

  typedef struct packed {
    logic [`PFA_DADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic                    wr;
    logic                    rd;
  } pfa_ds_req_t;

  typedef enum logic [1:0] {
    PFA_IRQ_IDLE    = 2'b00,
    PFA_IRQ_WAIT    = 2'b01,
    PFA_IRQ_SERVICE = 2'b10
  } pfa_irq_state_t;

endpackage

// file: design/pfa_stack_mem.sv
// Small memory for the return stack, with a registered read port.
// Assumes one clock; a write to the word being read is passed through.
`timescale 1ns/1ps
`include "pfa_consts.svh"

module pfa_stack_mem
  import pfa_pkg::*;
#(
  parameter int WIDTH = `PFA_PC_W,
  parameter int DEPTH = `PFA_STACK_DEPTH,
  parameter int AW    = `PFA_SP_W
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // The bypass keeps the top-of-stack word current right after a push.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// file: design/pfa_flow.sv
// Program counter, return stack, indirect window and interrupt timing.
// Assumes the decoder drives flow ops and data-space strobes on the
// instruction clock, and that a data RAM answers one cycle after a strobe.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pfa_consts.svh"

module pfa_flow
  import pfa_pkg::*;
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    RESETN,
  input  wire pfa_flow_t               FLOW,
  input  wire pfa_ds_req_t             DS_REQ,
  output logic [7:0]                   DS_RDATA,
  output pfa_ds_req_t                  RAM_REQ,
  input  wire logic [7:0]              RAM_RDATA,
  input  wire logic                    BANK_SELECT_HIGH,
  input  wire logic                    EXT_IRQ_EVENT,
  input  wire logic                    EXT_IRQ_FLAG_CLEAR,
  input  wire logic                    IRQ_ENABLE,
  output logic                         EXTERNAL_IRQ_FLAG,
  output logic                         IRQ_TAKEN,
  output logic [1:0]                   PHASE,
  output logic                         INSTR_CYCLE_EN,
  output logic [`PFA_PC_W-1:0]         PC
);

  ////////////////////////////////////////////////////////////////////////
  // Data-space decode and the indirect window.

  logic                    win;
  logic [`PFA_DADDR_W-1:0] eff_addr;
  logic                    win_self;
  logic                    hit_pc_low;
  logic                    hit_fp;
  logic                    hit_latch;
  logic                    hit_local;
  logic                    pc_low_wr;
  logic [7:0]              file_pointer;
  logic [`PFA_LATCH_W-1:0] pc_upper_latch;
  logic [7:0]              rdata_local;
  logic                    rd_from_ram;

  assign win        = DS_REQ.addr[6:0] == `PFA_ADR_WINDOW;
  assign eff_addr   = win ? {BANK_SELECT_HIGH, file_pointer} : DS_REQ.addr;
  assign win_self   = win && (eff_addr[6:0] == `PFA_ADR_WINDOW);
  assign hit_pc_low = eff_addr[6:0] == `PFA_ADR_PC_LOW;
  assign hit_fp     = eff_addr[6:0] == `PFA_ADR_FILE_PTR;
  assign hit_latch  = eff_addr[6:0] == `PFA_ADR_LATCH;
  // The stack pointer and upper counter bits have no address at all.
  assign hit_local  = win_self | hit_pc_low | hit_fp | hit_latch;
  assign pc_low_wr  = DS_REQ.wr && hit_pc_low;

  // A self-addressed window write is swallowed here; flags are not ours.
  always_comb begin
    RAM_REQ       = DS_REQ;
    RAM_REQ.addr  = eff_addr;
    RAM_REQ.wr    = DS_REQ.wr && !hit_local;
    RAM_REQ.rd    = DS_REQ.rd && !hit_local;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      file_pointer <= `PFA_FP_RESET;
    end else if (DS_REQ.wr && hit_fp) begin
      file_pointer <= DS_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      pc_upper_latch <= `PFA_LATCH_RESET;
    end else if (DS_REQ.wr && hit_latch) begin
      pc_upper_latch <= DS_REQ.wdata[`PFA_LATCH_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rdata_local <= 8'h00;
      rd_from_ram <= 1'b0;
    end else if (DS_REQ.rd) begin
      rd_from_ram <= !hit_local;
      if (hit_pc_low) begin
        rdata_local <= PC[7:0];
      end else if (hit_fp) begin
        rdata_local <= file_pointer;
      end else if (hit_latch) begin
        rdata_local <= {3'h0, pc_upper_latch};
      end else begin
        rdata_local <= 8'h00;
      end
    end else begin
      rd_from_ram <= 1'b0;
    end
  end

  assign DS_RDATA = rd_from_ram ? RAM_RDATA : rdata_local;

  ////////////////////////////////////////////////////////////////////////
  // Instruction phases: four clocks per instruction cycle.

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      PHASE <= `PFA_PHASE_FIRST;
    end else begin
      PHASE <= PHASE + 2'h1;
    end
  end

  assign INSTR_CYCLE_EN = PHASE == `PFA_PHASE_LAST;

  ////////////////////////////////////////////////////////////////////////
  // External interrupt flag and vectoring latency.

  logic           irq_window;
  logic           irq_held;
  logic           irq_start;
  logic           vector_now;
  logic [1:0]     lat_cnt;
  pfa_irq_state_t irq_state;

  assign irq_window = (PHASE == `PFA_PHASE_LAST) || (PHASE == `PFA_PHASE_FIRST);

  // An edge outside the window waits here, which is why asynchronous
  // sources can see one extra instruction cycle of latency.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      irq_held <= 1'b0;
    end else if (irq_window) begin
      irq_held <= 1'b0;
    end else if (EXT_IRQ_EVENT) begin
      irq_held <= 1'b1;
    end
  end

  // Setting wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      EXTERNAL_IRQ_FLAG <= 1'b0;
    end else if (irq_window && (EXT_IRQ_EVENT || irq_held)) begin
      EXTERNAL_IRQ_FLAG <= 1'b1;
    end else if (EXT_IRQ_FLAG_CLEAR) begin
      EXTERNAL_IRQ_FLAG <= 1'b0;
    end
  end

  assign irq_start  = (irq_state == PFA_IRQ_IDLE) && INSTR_CYCLE_EN &&
                      EXTERNAL_IRQ_FLAG && IRQ_ENABLE;
  assign vector_now = (irq_state == PFA_IRQ_WAIT) && INSTR_CYCLE_EN &&
                      IRQ_ENABLE && (lat_cnt == `PFA_IRQ_LAT - 2'h1);
  assign IRQ_TAKEN  = vector_now;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      irq_state <= PFA_IRQ_IDLE;
      lat_cnt   <= 2'h0;
    end else begin
      unique case (irq_state)
        PFA_IRQ_IDLE: begin
          if (irq_start) begin
            irq_state <= PFA_IRQ_WAIT;
            lat_cnt   <= 2'h1;
          end
        end
        PFA_IRQ_WAIT: begin
          if (!IRQ_ENABLE) begin
            irq_state <= PFA_IRQ_IDLE;
          end else if (vector_now) begin
            irq_state <= PFA_IRQ_SERVICE;
          end else if (INSTR_CYCLE_EN) begin
            lat_cnt <= lat_cnt + 2'h1;
          end
        end
        PFA_IRQ_SERVICE: begin
          if (FLOW.op == PFA_OP_RETIRQ) begin
            irq_state <= PFA_IRQ_IDLE;
          end
        end
        default: begin
          irq_state <= PFA_IRQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack: circular, no overflow or underflow indication.

  logic                 push;
  logic                 pop;
  logic                 flow_ok;
  logic [`PFA_SP_W-1:0] sp;
  logic [`PFA_SP_W-1:0] next_sp;
  logic [`PFA_PC_W-1:0] stack_top;
  logic [`PFA_PC_W-1:0] jump_pc;

  assign flow_ok = !vector_now && !pc_low_wr;
  assign push    = vector_now || (flow_ok && (FLOW.op == PFA_OP_CALL));
  assign pop     = flow_ok && ((FLOW.op == PFA_OP_RETURN) ||
                               (FLOW.op == PFA_OP_RETLIT) ||
                               (FLOW.op == PFA_OP_RETIRQ));

  // The pointer simply wraps; nothing records lost entries.
  always_comb begin
    next_sp = sp;
    if (push) begin
      next_sp = sp + `PFA_SP_W'(1);
    end else if (pop) begin
      next_sp = sp - `PFA_SP_W'(1);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      sp <= '0;
    end else begin
      sp <= next_sp;
    end
  end

  pfa_stack_mem #(
    .WIDTH (`PFA_PC_W),
    .DEPTH (`PFA_STACK_DEPTH),
    .AW    (`PFA_SP_W)
  ) u_stack (
    .clk    (SYS_CLK),
    .resetn (RESETN),
    .we     (push),
    .waddr  (sp),
    .wdata  (PC),
    .raddr  (next_sp - `PFA_SP_W'(1)),
    .rdata  (stack_top)
  );

  ////////////////////////////////////////////////////////////////////////
  // Program counter.

  assign jump_pc = {pc_upper_latch[4:3], FLOW.target};

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      PC <= `PFA_PC_RESET;
    end else if (vector_now) begin
      PC <= `PFA_VECTOR;
    end else if (pc_low_wr) begin
      // No carry reaches the upper bits from a low-byte sum.
      PC <= {pc_upper_latch, DS_REQ.wdata};
    end else if (pop) begin
      PC <= stack_top;
    end else if ((FLOW.op == PFA_OP_GOTO) || (FLOW.op == PFA_OP_CALL)) begin
      PC <= jump_pc;
    end else if (FLOW.op == PFA_OP_STEP) begin
      PC <= PC + `PFA_PC_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  AST_RESET_PC: assert property (disable iff (1'b0)
    !RESETN |=> (PC == `PFA_PC_RESET))
    else $error("Counter not cleared by reset.");

  AST_LOW_WRITE: assert property (
    (pc_low_wr && !vector_now) |=>
      (PC == {$past(pc_upper_latch), $past(DS_REQ.wdata)}))
    else $error("Low-byte write did not load all bits.");

  AST_JUMP_LOAD: assert property (
    (flow_ok && (FLOW.op == PFA_OP_GOTO)) |=>
      (PC == {$past(pc_upper_latch[4:3]), $past(FLOW.target)}))
    else $error("Jump did not load the expected address.");

  AST_CALL_RETURN: assert property (
    (flow_ok && (FLOW.op == PFA_OP_CALL)) ##1
      (flow_ok && (FLOW.op == PFA_OP_RETURN)) |=> (PC == $past(PC, 2)))
    else $error("Return did not restore the pushed address.");

  AST_LATCH_KEPT: assert property (
    ((push || pop) && !(DS_REQ.wr && hit_latch)) |=> $stable(pc_upper_latch))
    else $error("Stack action changed the latch.");

  AST_SP_WRAP: assert property (
    push |=> (sp == $past(sp) + `PFA_SP_W'(1)))
    else $error("Stack pointer did not advance by one.");

  AST_WINDOW_ZERO: assert property (
    (DS_REQ.rd && win_self) |=> (DS_RDATA == 8'h00))
    else $error("Self-addressed window read was not zero.");

  AST_WINDOW_NOSTORE: assert property (
    (DS_REQ.wr && win_self) |-> !RAM_REQ.wr ##1 $stable(file_pointer))
    else $error("Self-addressed window write stored data.");

  AST_INDIRECT_ADDR: assert property (
    (win && !win_self) |-> (RAM_REQ.addr == {BANK_SELECT_HIGH, file_pointer}))
    else $error("Indirect address not formed from bank bit and pointer.");

  AST_FLAG_PHASE: assert property (
    $rose(EXTERNAL_IRQ_FLAG) |->
      (($past(PHASE) == `PFA_PHASE_LAST) || ($past(PHASE) == `PFA_PHASE_FIRST)))
    else $error("External flag set outside its phase window.");

  AST_LATENCY: assert property (
    (irq_start ##1 IRQ_ENABLE [*8]) |-> (vector_now && PC != `PFA_VECTOR)
      ##1 (PC == `PFA_VECTOR))
    else $error("Interrupt vectoring latency is wrong.");

  AST_STEP_INC: assert property (
    (flow_ok && (FLOW.op == PFA_OP_STEP)) |=> (PC == $past(PC) + `PFA_PC_W'(1)))
    else $error("Step did not advance the counter by one.");

  AST_VECTOR_PUSH: assert property (
    vector_now |=> ((PC == `PFA_VECTOR) && (stack_top == $past(PC))))
    else $error("Vectoring did not push the counter.");

  AST_POP_LOAD: assert property (
    pop |=> (PC == $past(stack_top)))
    else $error("Return did not load the top of stack.");

  AST_SP_POP: assert property (
    pop |=> (sp == $past(sp) - `PFA_SP_W'(1)))
    else $error("Stack pointer did not step back by one.");

  AST_WINDOW_PASS: assert property (
    (win && !hit_local && (DS_REQ.rd || DS_REQ.wr)) |->
      ((RAM_REQ.rd == DS_REQ.rd) && (RAM_REQ.wr == DS_REQ.wr)))
    else $error("Indirect access did not reach the data memory.");

  AST_PHASE_WRAP: assert property (
    INSTR_CYCLE_EN |=> (PHASE == `PFA_PHASE_FIRST))
    else $error("Instruction cycle did not restart at the first phase.");

  AST_FLAG_SET_WINS: assert property (
    (irq_window && EXT_IRQ_EVENT) |=> EXTERNAL_IRQ_FLAG)
    else $error("Flag not set by an event in its phase window.");

  COV_CALL:    cover property (push && !vector_now);
  COV_VECTOR:  cover property (vector_now);
  COV_LOW_WR:  cover property (pc_low_wr);
  COV_WIN_RD:  cover property (DS_REQ.rd && win_self);

endmodule

// file: verif/pfa_ram_model.sv
// Behavioural data RAM that stands behind the block's data-space port.
// Assumes one clock and requests that change just after its rising edge.
`timescale 1ns/1ps

module pfa_ram_model
  import pfa_pkg::*;
(
  input  wire logic        clk,
  input  wire pfa_ds_req_t req,
  output logic [7:0]       rdata,
  output int               wr_count
);
  logic [7:0] mem [512];

  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
    rdata    = 8'h00;
    wr_count = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outside the answer cycle the data lines toggle, so a late sample is caught.
  always @(posedge clk) begin
    if (req.rd) begin
      rdata <= mem[req.addr];
    end else begin
      rdata <= ~rdata;
    end
    if (req.wr) begin
      mem[req.addr] <= req.wdata;
      wr_count      <= wr_count + 1;
    end
  end
endmodule

// file: verif/pfa_flow_tb.sv
// Self-checking bench for the program-flow and indirect-addressing block.
// Assumes the constants header on the include path and the RAM model beside it.
`timescale 1ns/1ps
`include "pfa_consts.svh"

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module pfa_flow_tb
  import pfa_pkg::*;
;
  localparam logic [8:0] A_WIN = {2'b00, `PFA_ADR_WINDOW};
  localparam logic [8:0] A_PCL = {2'b00, `PFA_ADR_PC_LOW};
  localparam logic [8:0] A_FP  = {2'b00, `PFA_ADR_FILE_PTR};
  localparam logic [8:0] A_LAT = {2'b00, `PFA_ADR_LATCH};

  logic                 sys_clk;
  logic                 resetn;
  pfa_flow_t            flow;
  pfa_ds_req_t          ds_req;
  pfa_ds_req_t          ram_req;
  logic [7:0]           ds_rdata;
  logic [7:0]           ram_rdata;
  logic [7:0]           rd_val;
  logic                 bank_hi;
  logic                 irq_event;
  logic                 irq_clear;
  logic                 irq_en;
  logic                 irq_flag;
  logic                 irq_taken;
  logic                 cyc_en;
  logic [1:0]           phase;
  logic [`PFA_PC_W-1:0] pc;
  logic [`PFA_PC_W-1:0] pc_keep;
  logic [`PFA_PC_W-1:0] pushed [10];
  pfa_op_t              pops [3];
  int                   num_errors;
  int                   cmp_count;
  int                   ram_writes;
  int                   snap;
  int                   n;

  pfa_flow dut_u (
    .SYS_CLK            (sys_clk),
    .RESETN             (resetn),
    .FLOW               (flow),
    .DS_REQ             (ds_req),
    .DS_RDATA           (ds_rdata),
    .RAM_REQ            (ram_req),
    .RAM_RDATA          (ram_rdata),
    .BANK_SELECT_HIGH   (bank_hi),
    .EXT_IRQ_EVENT      (irq_event),
    .EXT_IRQ_FLAG_CLEAR (irq_clear),
    .IRQ_ENABLE         (irq_en),
    .EXTERNAL_IRQ_FLAG  (irq_flag),
    .IRQ_TAKEN          (irq_taken),
    .PHASE              (phase),
    .INSTR_CYCLE_EN     (cyc_en),
    .PC                 (pc)
  );

  pfa_ram_model ram_u (
    .clk      (sys_clk),
    .req      (ram_req),
    .rdata    (ram_rdata),
    .wr_count (ram_writes)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ds_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    ds_req.wr <= 1'b0;
    #1;
  endtask

  // Read data from the RAM stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [8:0] a);
    @(posedge sys_clk);
    ds_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    ds_req.rd <= 1'b0;
    #1 rd_val = ds_rdata;
  endtask

  task automatic op(input pfa_op_t o, input logic [10:0] t);
    @(posedge sys_clk);
    flow <= '{op: o, target: t};
    @(posedge sys_clk);
    flow <= '{op: PFA_OP_NONE, target: 11'h000};
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn     = 1'b0;
    flow       = '{op: PFA_OP_NONE, target: 11'h000};
    ds_req     = '0;
    bank_hi    = 1'b0;
    irq_event  = 1'b0;
    irq_clear  = 1'b0;
    irq_en     = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    pops       = '{PFA_OP_RETURN, PFA_OP_RETLIT, PFA_OP_RETIRQ};
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    #1 `CHK(pc, `PFA_PC_RESET)
    wr(A_LAT, 8'h1F);
    wr(A_PCL, 8'h34);
    `CHK(pc, 13'h1F34)
    rd(A_PCL);
    `CHK(rd_val, 8'h34)
    rd(A_LAT);
    `CHK(rd_val, 8'h1F)
    op(PFA_OP_GOTO, 11'h123);
    `CHK(pc, 13'h1923)
    // Ten calls overrun the eight entries; the pops must wrap round.
    for (int i = 0; i < 10; i++) begin
      pushed[i] = pc;
      op(PFA_OP_CALL, 11'h100 + 11'(i));
      `CHK(pc, {2'b11, 11'h100 + 11'(i)})
    end
    for (int i = 0; i < 9; i++) begin
      op(pops[i % 3], 11'h000);
      `CHK(pc, pushed[9 - (i % 8)])
    end
    rd(A_LAT);
    `CHK(rd_val, 8'h1F)
    wr(9'h145, 8'hA5);
    wr(9'h045, 8'h3C);
    wr(A_FP, 8'h45);
    @(posedge sys_clk) bank_hi <= 1'b1;
    rd(A_WIN);
    `CHK(rd_val, 8'hA5)
    @(posedge sys_clk) bank_hi <= 1'b0;
    rd(A_WIN);
    `CHK(rd_val, 8'h3C)
    wr(A_WIN, 8'h77);
    rd(9'h045);
    `CHK(rd_val, 8'h77)
    wr(A_FP, 8'h80);
    snap = ram_writes;
    wr(A_WIN, 8'hEE);
    `CHK(ram_writes, snap)
    rd(A_WIN);
    `CHK(rd_val, 8'h00)
    // An event sampled in the second phase is held back until the fourth.
    for (n = 0; n < 8 && phase !== 2'h0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(phase, `PFA_PHASE_FIRST)
    @(posedge sys_clk) irq_event <= 1'b1;
    @(posedge sys_clk) irq_event <= 1'b0;
    #1 `CHK(irq_flag, 1'b0)
    repeat (4) @(posedge sys_clk);
    #1 `CHK(irq_flag, 1'b1)
    pc_keep = pc;
    @(posedge sys_clk) irq_en <= 1'b1;
    #1 n = 1;
    while (irq_taken !== 1'b1) begin
      if (n == 40) begin
        num_errors++;
        give_verdict();
      end
      @(posedge sys_clk);
      #1 n++;
    end
    `CHK((n >= 8 && n <= 20), 1'b1)
    `CHK(cyc_en, 1'b1)
    @(posedge sys_clk);
    irq_en    <= 1'b0;
    irq_clear <= 1'b1;
    #1 `CHK(pc, `PFA_VECTOR)
    `CHK(irq_taken, 1'b0)
    @(posedge sys_clk) irq_clear <= 1'b0;
    #1 `CHK(irq_flag, 1'b0)
    op(PFA_OP_RETIRQ, 11'h000);
    `CHK(pc, pc_keep)
    // An event and a clear in one window cycle: the set must win.
    for (n = 0; n < 8 && phase !== `PFA_PHASE_LAST; n++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(phase, `PFA_PHASE_LAST)
    @(posedge sys_clk);
    irq_event <= 1'b1;
    irq_clear <= 1'b1;
    @(posedge sys_clk);
    irq_event <= 1'b0;
    irq_clear <= 1'b0;
    #1 `CHK(irq_flag, 1'b1)
    wr(A_LAT, 8'h01);
    wr(A_PCL, 8'hFE);
    op(PFA_OP_STEP, 11'h000);
    `CHK(pc, 13'h01FF)
    // A computed jump past a low-byte wrap needs the latch bumped by software.
    wr(A_PCL, 8'h03);
    `CHK(pc, 13'h0103)
    wr(A_LAT, 8'h02);
    wr(A_PCL, 8'h03);
    `CHK(pc, 13'h0203)
    // Call and return on consecutive cycles.
    pc_keep = pc;
    @(posedge sys_clk) flow <= '{op: PFA_OP_CALL, target: 11'h2AA};
    @(posedge sys_clk) flow <= '{op: PFA_OP_RETURN, target: 11'h000};
    #1 `CHK(pc, 13'h02AA)
    @(posedge sys_clk) flow <= '{op: PFA_OP_NONE, target: 11'h000};
    #1 `CHK(pc, pc_keep)
    wr(A_LAT, 8'h1F);
    wr(A_PCL, 8'hFF);
    op(PFA_OP_STEP, 11'h000);
    `CHK(pc, 13'h0000)
    // A second reset in mid-run clears all state again, except the return-stack memory, which has no reset.
    @(posedge sys_clk) resetn <= 1'b0;
    @(posedge sys_clk) resetn <= 1'b1;
    #1 `CHK(pc, `PFA_PC_RESET)
    `CHK(phase, `PFA_PHASE_FIRST)
    `CHK(irq_flag, 1'b0)
    rd(A_LAT);
    `CHK(rd_val, 8'h00)
    give_verdict();
  end
endmodule
